// ===== uart_pkg.sv
// Package: register map, field layout, timing and types of the serial control block
package uart_pkg;

    // ****************************************************************
    // Register byte offsets on the Avalon-MM slave
    // ****************************************************************
    localparam logic [7:0] CTRL_OFS = 8'h98;
    localparam logic [7:0] DATA_OFS = 8'h9C;
    localparam logic [7:0] AUXC_OFS = 8'hA0;
    localparam logic [7:0] STAT_OFS = 8'hA4;
    localparam logic [7:0] BAUD_OFS = 8'hA8;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] AUXC_RST = 4'h0;
    localparam logic [15:0] BAUD_RST = 16'h0010;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_B7 = 7;
    localparam int AUX_FSEL_BIT = 0;
    localparam int AUX_BRR_BIT = 1;
    localparam int AUX_ILO_BIT = 2;
    localparam int AUX_DBL_BIT = 3;
    localparam int STAT_FERR_BIT = 0;
    localparam int STAT_BR_BIT = 1;

    // ****************************************************************
    // Cycle counts, break length in bits and last data bit index
    // ****************************************************************
    localparam logic [15:0] M0_BIT_CYC = 16'h0010;
    localparam logic [15:0] M2_SLOW_CYC = 16'h0020;
    localparam logic [15:0] M2_FAST_CYC = 16'h0010;
    localparam logic [15:0] MIN_BIT_CYC = 16'h0010;
    localparam logic [3:0] BREAK_BITS = 4'hB;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_8BIT = 2'b01,
        MODE_9FIX = 2'b10,
        MODE_9VAR = 2'b11
    } mode_t;

    typedef struct packed {
        logic mode_sel_high;
        logic mode_sel_low;
        logic multiproc_filter_en;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_int_flag;
        logic rx_int_flag;
    } ctrl_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_NINTH = 3'b011,
        RX_STOP = 3'b100,
        RX_BRK = 3'b101
    } rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_NINTH = 3'b011,
        TX_STOP = 3'b100,
        TX_SHIFT = 3'b101
    } tx_state_t;

endpackage : uart_pkg

// ===== uart_bit_timer.sv
// Bit period timer giving mid-bit and end-of-bit strobes
`timescale 1ns/10ps
module uart_bit_timer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_restart,
    input wire logic [15:0] i_period,
    output logic o_mid,
    output logic o_end
);

    logic [15:0] cnt_q;

    // Strobes are held off during a restart so a new bit never ends early
    assign o_mid = (cnt_q == (i_period >> 1)) & ~i_restart;
    assign o_end = (cnt_q == (i_period - 16'h0001)) & ~i_restart;

    // Free running count, wraps each bit period
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            cnt_q <= 16'h0000;
        end
        else if (i_restart || o_end)
        begin
            cnt_q <= 16'h0000;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

endmodule : uart_bit_timer

// ===== uart_serial_ctrl.sv
// Serial port control: break detect, framing, control register, four modes
`timescale 1ns/10ps
module uart_serial_ctrl (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic I_RXD,
    output logic O_RXD,
    output logic O_RXD_OE,
    output logic O_TXD,
    output logic O_BREAK_RESET,
    output logic O_PROG_FORCE
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    uart_pkg::ctrl_t ctrl_q;
    uart_pkg::mode_t mode;
    uart_pkg::rx_state_t rx_st_q;
    uart_pkg::tx_state_t tx_st_q;
    logic [3:0] aux_q;
    logic [15:0] baud_q;
    logic ferr_q;
    logic brk_q;
    logic [7:0] rx_buf_q;
    logic [7:0] rx_sh_q;
    logic [7:0] tx_sh_q;
    logic [2:0] rx_cnt_q;
    logic [2:0] tx_cnt_q;
    logic [3:0] brk_cnt_q;
    logic ninth_q;
    logic sh_rx_q;
    logic rxd_s1_q;
    logic rxd_s2_q;
    logic rxd_prev_q;
    logic [31:0] rd_mux;
    logic [15:0] bit_cyc;
    logic req;
    logic wr;
    logic wr_ctrl;
    logic wr_data;
    logic wr_stat;
    logic fsel;
    logic rx_mid;
    logic rx_end;
    logic tx_mid;
    logic tx_end;
    logic rx_go;
    logic tx_go;
    logic brk_det;
    logic rxf_set;
    logic txf_set;
    logic ferr_set;
    logic r9_set;
    logic r9_val;

    assign mode = uart_pkg::mode_t'({ctrl_q.mode_sel_high, ctrl_q.mode_sel_low});
    assign fsel = aux_q[uart_pkg::AUX_FSEL_BIT];

    // ****************************************************************
    // Avalon-MM slave
    // ****************************************************************
    // Every access is answered one cycle after it is presented
    assign req = I_AVS_READ | I_AVS_WRITE;
    assign wr = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
    assign wr_ctrl = wr && (I_AVS_ADDRESS == uart_pkg::CTRL_OFS);
    assign wr_data = wr && (I_AVS_ADDRESS == uart_pkg::DATA_OFS);
    assign wr_stat = wr && (I_AVS_ADDRESS == uart_pkg::STAT_OFS);

    // Read mux; bit 7 of control follows the framing select
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (I_AVS_ADDRESS == uart_pkg::CTRL_OFS)
        begin
            rd_mux[7:0] = ctrl_q;
            rd_mux[uart_pkg::CTRL_B7] = fsel ? ferr_q : ctrl_q.mode_sel_high;
        end
        else if (I_AVS_ADDRESS == uart_pkg::DATA_OFS)
        begin
            rd_mux[7:0] = rx_buf_q;
        end
        else if (I_AVS_ADDRESS == uart_pkg::AUXC_OFS)
        begin
            rd_mux[3:0] = aux_q;
        end
        else if (I_AVS_ADDRESS == uart_pkg::STAT_OFS)
        begin
            rd_mux[3:0] = {rx_st_q != uart_pkg::RX_IDLE, tx_st_q != uart_pkg::TX_IDLE, brk_q, ferr_q};
        end
        else if (I_AVS_ADDRESS == uart_pkg::BAUD_OFS)
        begin
            rd_mux[15:0] = baud_q;
        end
    end

    // Wait request drops for exactly one cycle per access
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= 32'h0000_0000;
        end
        else
        begin
            O_AVS_WAITREQUEST <= ~(req & O_AVS_WAITREQUEST);
            if (I_AVS_READ && O_AVS_WAITREQUEST)
            begin
                O_AVS_READDATA <= rd_mux;
            end
        end
    end

    // Auxiliary control and baud divisor
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            aux_q <= uart_pkg::AUXC_RST;
            baud_q <= uart_pkg::BAUD_RST;
        end
        else if (wr && (I_AVS_ADDRESS == uart_pkg::AUXC_OFS))
        begin
            aux_q <= I_AVS_WRITEDATA[3:0];
        end
        else if (wr && (I_AVS_ADDRESS == uart_pkg::BAUD_OFS))
        begin
            baud_q <= I_AVS_WRITEDATA[15:0];
        end
    end

    // Control register; hardware sets win over a software clear
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            ctrl_q <= uart_pkg::CTRL_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q[6:0] <= I_AVS_WRITEDATA[6:0];
                if (!fsel)
                begin
                    ctrl_q.mode_sel_high <= I_AVS_WRITEDATA[uart_pkg::CTRL_B7];
                end
            end
            if (r9_set)
            begin
                ctrl_q.rx_ninth_bit <= r9_val;
            end
            if (rxf_set)
            begin
                ctrl_q.rx_int_flag <= 1'b1;
            end
            if (txf_set)
            begin
                ctrl_q.tx_int_flag <= 1'b1;
            end
        end
    end

    // Framing error: cleared only by software, never by a good frame
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            ferr_q <= 1'b0;
        end
        else if (ferr_set)
        begin
            ferr_q <= 1'b1;
        end
        else if (wr_ctrl && fsel)
        begin
            ferr_q <= I_AVS_WRITEDATA[uart_pkg::CTRL_B7];
        end
        else if (wr_stat && I_AVS_WRITEDATA[uart_pkg::STAT_FERR_BIT])
        begin
            ferr_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Line sampling and bit timing
    // ****************************************************************
    // Two-stage synchroniser on the receive pin
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
            rxd_prev_q <= 1'b1;
        end
        else
        begin
            rxd_s1_q <= I_RXD;
            rxd_s2_q <= rxd_s1_q;
            rxd_prev_q <= rxd_s2_q;
        end
    end

    // Bit period per mode; variable rate is floored to keep a mid point
    always_comb
    begin
        bit_cyc = (baud_q < uart_pkg::MIN_BIT_CYC) ? uart_pkg::MIN_BIT_CYC : baud_q;
        if (mode == uart_pkg::MODE_SHIFT)
        begin
            bit_cyc = uart_pkg::M0_BIT_CYC;
        end
        else if (mode == uart_pkg::MODE_9FIX)
        begin
            bit_cyc = aux_q[uart_pkg::AUX_DBL_BIT] ? uart_pkg::M2_FAST_CYC : uart_pkg::M2_SLOW_CYC;
        end
    end

    // Receive timer realigns to a start edge; otherwise it free-runs for break counting
    assign rx_go = (rx_st_q == uart_pkg::RX_IDLE) && ctrl_q.rx_enable && (mode != uart_pkg::MODE_SHIFT)
        && rxd_prev_q && !rxd_s2_q;

    uart_bit_timer u_rx_timer (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_restart(rx_go),
        .i_period(bit_cyc),
        .o_mid(rx_mid),
        .o_end(rx_end)
    );

    uart_bit_timer u_tx_timer (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_restart(tx_go),
        .i_period(bit_cyc),
        .o_mid(tx_mid),
        .o_end(tx_end)
    );

    // ****************************************************************
    // Break detection
    // ****************************************************************
    // Counts low samples across frame boundaries, saturating at the break length
    assign brk_det = rx_mid && !rxd_s2_q && (mode != uart_pkg::MODE_SHIFT)
        && (brk_cnt_q == (uart_pkg::BREAK_BITS - 4'h1));

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            brk_cnt_q <= 4'h0;
        end
        else if (rx_mid)
        begin
            if (rxd_s2_q)
            begin
                brk_cnt_q <= 4'h0;
            end
            else if (brk_cnt_q != uart_pkg::BREAK_BITS)
            begin
                brk_cnt_q <= brk_cnt_q + 4'h1;
            end
        end
    end

    // Break flag and the device reset request it can raise
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            brk_q <= 1'b0;
            O_BREAK_RESET <= 1'b0;
            O_PROG_FORCE <= 1'b0;
        end
        else
        begin
            if (brk_det)
            begin
                brk_q <= 1'b1;
            end
            else if (wr_stat && I_AVS_WRITEDATA[uart_pkg::STAT_BR_BIT])
            begin
                brk_q <= 1'b0;
            end
            O_BREAK_RESET <= brk_det & aux_q[uart_pkg::AUX_BRR_BIT];
            O_PROG_FORCE <= brk_det & aux_q[uart_pkg::AUX_BRR_BIT];
        end
    end

    // ****************************************************************
    // Receiver for modes 1 to 3
    // ****************************************************************
    // Flag strobes from the receive frame and the shift engine
    always_comb
    begin
        rxf_set = 1'b0;
        ferr_set = brk_det;
        r9_set = 1'b0;
        r9_val = rxd_s2_q;
        if (tx_st_q == uart_pkg::TX_SHIFT && sh_rx_q && tx_end && tx_cnt_q == uart_pkg::LAST_DATA_BIT)
        begin
            rxf_set = 1'b1;
        end
        if (rx_mid && !brk_det && rx_st_q == uart_pkg::RX_NINTH && !fsel)
        begin
            r9_set = 1'b1;
            rxf_set = rxd_s2_q || !ctrl_q.multiproc_filter_en;
        end
        if (rx_mid && !brk_det && rx_st_q == uart_pkg::RX_STOP)
        begin
            ferr_set = !rxd_s2_q;
            if (mode == uart_pkg::MODE_8BIT)
            begin
                r9_set = 1'b1;
                rxf_set = 1'b1;
            end
            else if (fsel)
            begin
                r9_set = 1'b1;
                r9_val = ninth_q;
                rxf_set = ninth_q || !ctrl_q.multiproc_filter_en;
            end
        end
    end

    // Receive frame sequencing; a break preempts any state
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            rx_st_q <= uart_pkg::RX_IDLE;
            rx_cnt_q <= 3'h0;
            ninth_q <= 1'b0;
        end
        else if (brk_det)
        begin
            rx_st_q <= uart_pkg::RX_BRK;
        end
        else if (!ctrl_q.rx_enable && rx_st_q != uart_pkg::RX_BRK)
        begin
            rx_st_q <= uart_pkg::RX_IDLE;
        end
        else if (rx_go)
        begin
            rx_st_q <= uart_pkg::RX_START;
            rx_cnt_q <= 3'h0;
        end
        else if (rx_mid)
        begin
            case (rx_st_q)
                uart_pkg::RX_START: rx_st_q <= rxd_s2_q ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
                uart_pkg::RX_DATA:
                begin
                    rx_cnt_q <= rx_cnt_q + 3'h1;
                    if (rx_cnt_q == uart_pkg::LAST_DATA_BIT)
                    begin
                        rx_st_q <= (mode == uart_pkg::MODE_8BIT) ? uart_pkg::RX_STOP : uart_pkg::RX_NINTH;
                    end
                end
                uart_pkg::RX_NINTH:
                begin
                    ninth_q <= rxd_s2_q;
                    rx_st_q <= uart_pkg::RX_STOP;
                end
                uart_pkg::RX_STOP: rx_st_q <= uart_pkg::RX_IDLE;
                uart_pkg::RX_BRK: rx_st_q <= rxd_s2_q ? uart_pkg::RX_IDLE : uart_pkg::RX_BRK;
                default: rx_st_q <= uart_pkg::RX_IDLE;
            endcase
        end
    end

    // Receive shifter (LSB first) and buffer, loaded as the flag is raised
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            rx_sh_q <= uart_pkg::BYTE_RST;
            rx_buf_q <= uart_pkg::BYTE_RST;
        end
        else
        begin
            if (rx_mid && rx_st_q == uart_pkg::RX_DATA)
            begin
                rx_sh_q <= {rxd_s2_q, rx_sh_q[7:1]};
            end
            else if (tx_mid && tx_st_q == uart_pkg::TX_SHIFT && sh_rx_q)
            begin
                rx_sh_q <= {rxd_s2_q, rx_sh_q[7:1]};
            end
            if (rxf_set)
            begin
                rx_buf_q <= rx_sh_q; // All eight bits are already shifted in, in every mode
            end
        end
    end

    // ****************************************************************
    // Transmitter and mode 0 shift engine
    // ****************************************************************
    // Mode 0 receive starts when enabled and the previous byte is taken
    assign tx_go = (tx_st_q == uart_pkg::TX_IDLE) && (wr_data || (mode == uart_pkg::MODE_SHIFT
        && ctrl_q.rx_enable && !ctrl_q.rx_int_flag));

    assign txf_set = (tx_end && tx_st_q == uart_pkg::TX_SHIFT && !sh_rx_q && tx_cnt_q == uart_pkg::LAST_DATA_BIT)
        || (tx_st_q == uart_pkg::TX_STOP && (aux_q[uart_pkg::AUX_ILO_BIT] ? tx_end : tx_mid && 1'b0))
        || (tx_end && !aux_q[uart_pkg::AUX_ILO_BIT] && (tx_st_q == uart_pkg::TX_NINTH
        || (tx_st_q == uart_pkg::TX_DATA && mode == uart_pkg::MODE_8BIT
        && tx_cnt_q == uart_pkg::LAST_DATA_BIT)));

    // Pins change only on bit edges, except the mode 0 shift clock which rises at mid-bit; a data write while busy is dropped
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_N)
        begin
            tx_st_q <= uart_pkg::TX_IDLE;
            tx_sh_q <= uart_pkg::BYTE_RST;
            tx_cnt_q <= 3'h0;
            sh_rx_q <= 1'b0;
            O_TXD <= 1'b1;
            O_RXD <= 1'b1;
            O_RXD_OE <= 1'b0;
        end
        else if (tx_go)
        begin
            tx_sh_q <= I_AVS_WRITEDATA[7:0];
            tx_cnt_q <= 3'h0;
            sh_rx_q <= !wr_data;
            if (mode == uart_pkg::MODE_SHIFT)
            begin
                tx_st_q <= uart_pkg::TX_SHIFT;
                O_TXD <= 1'b0;
                O_RXD <= I_AVS_WRITEDATA[0];
                O_RXD_OE <= wr_data;
            end
            else
            begin
                tx_st_q <= uart_pkg::TX_START;
                O_TXD <= 1'b0;
            end
        end
        else if (tx_st_q == uart_pkg::TX_SHIFT && tx_mid)
        begin
            O_TXD <= 1'b1;
        end
        else if (tx_end)
        begin
            case (tx_st_q)
                uart_pkg::TX_SHIFT:
                begin
                    tx_cnt_q <= tx_cnt_q + 3'h1;
                    tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                    O_RXD <= tx_sh_q[1];
                    if (tx_cnt_q == uart_pkg::LAST_DATA_BIT)
                    begin
                        tx_st_q <= uart_pkg::TX_IDLE;
                        O_RXD <= 1'b1;
                        O_RXD_OE <= 1'b0;
                    end
                    else
                    begin
                        O_TXD <= 1'b0;
                    end
                end
                uart_pkg::TX_START:
                begin
                    tx_st_q <= uart_pkg::TX_DATA;
                    O_TXD <= tx_sh_q[0];
                end
                uart_pkg::TX_DATA:
                begin
                    tx_cnt_q <= tx_cnt_q + 3'h1;
                    tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                    O_TXD <= tx_sh_q[1];
                    if (tx_cnt_q == uart_pkg::LAST_DATA_BIT)
                    begin
                        tx_st_q <= (mode == uart_pkg::MODE_8BIT) ? uart_pkg::TX_STOP : uart_pkg::TX_NINTH;
                        O_TXD <= (mode == uart_pkg::MODE_8BIT) ? 1'b1 : ctrl_q.tx_ninth_bit;
                    end
                end
                uart_pkg::TX_NINTH:
                begin
                    tx_st_q <= uart_pkg::TX_STOP;
                    O_TXD <= 1'b1;
                end
                uart_pkg::TX_STOP: tx_st_q <= uart_pkg::TX_IDLE;
                default: tx_st_q <= uart_pkg::TX_IDLE;
            endcase
        end
    end

endmodule : uart_serial_ctrl

// ===== uart_serial_ctrl_assertions.sv
// Checker: port timing of the serial control block
`timescale 1ns/10ps
module uart_serial_ctrl_checker (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_RXD,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic O_RXD,
    input wire logic O_RXD_OE,
    input wire logic O_TXD,
    input wire logic O_BREAK_RESET,
    input wire logic O_PROG_FORCE
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    // Shift clock rises on the mid strobe: low nine cycles, high seven, of each 16-cycle bit
    sequence s_low9;
        !O_TXD [*8] ##1 !O_TXD ##1 O_TXD;
    endsequence
    property p_clk_low; O_RXD_OE && $fell(O_TXD) |-> s_low9; endproperty
    a_clk_low: assert property (p_clk_low) else $error("shift clock low phase");
    property p_clk_high; O_RXD_OE && $rose(O_TXD) |-> O_TXD [*7] ##1 (!O_TXD || !O_RXD_OE); endproperty
    a_clk_high: assert property (p_clk_high) else $error("shift clock high phase");
    // Data moves only on the falling shift clock, so the far side samples it settled
    property p_data_edge; O_RXD_OE && $past(O_RXD_OE) && $changed(O_RXD) |-> $fell(O_TXD); endproperty
    a_data_edge: assert property (p_data_edge) else $error("shift data moved off edge");
    property p_oe_start; $rose(O_RXD_OE) |-> !O_TXD; endproperty
    a_oe_start: assert property (p_oe_start) else $error("shift start not low");
    property p_wait_one; !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    // A break needs a long low line; two samples eight cycles apart must both be low
    property p_brk_cause; O_BREAK_RESET |-> !$past(I_RXD, 8) && !$past(I_RXD, 16); endproperty
    a_brk_cause: assert property (p_brk_cause) else $error("break with high line");
    property p_brk_gap; O_BREAK_RESET |=> !O_BREAK_RESET [*8]; endproperty
    a_brk_gap: assert property (p_brk_gap) else $error("break pulse repeated");
    property p_prog_pair; O_BREAK_RESET == O_PROG_FORCE; endproperty
    a_prog_pair: assert property (p_prog_pair) else $error("reset and program force differ");
endmodule : uart_serial_ctrl_checker
bind uart_serial_ctrl uart_serial_ctrl_checker u_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N),
    .I_RXD(I_RXD), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_RXD(O_RXD), .O_RXD_OE(O_RXD_OE),
    .O_TXD(O_TXD), .O_BREAK_RESET(O_BREAK_RESET), .O_PROG_FORCE(O_PROG_FORCE));

// ===== uart_station.sv
// Remote serial station on the receive and transmit lines
`timescale 1ns/10ps
module uart_station #(parameter int BIT_NS = 1600) (
    input wire logic i_txd,
    output logic o_rxd
);
    initial o_rxd = 1'b1;
    // Bits LSB first, then one idle bit at the pulled-up level so a receiver can rearm
    task send(input logic [15:0] f, input int n);
        for (int i = 0; i <= n; i++)
        begin
            o_rxd <= (i < n) ? f[i] : 1'b1;
            #BIT_NS;
        end
    endtask : send
    // Mid-bit capture of one frame; unknowns stay if no start bit comes
    task grab(output logic [10:0] f);
        int t;
        f = {11{1'bx}};
        for (t = 0; i_txd !== 1'b0 && t < 500; t++)
            #20;
        #(BIT_NS / 2);
        for (int i = 0; i < 11 && t < 500; i++)
        begin
            f[i] = i_txd;
            #BIT_NS;
        end
    endtask : grab
endmodule : uart_station

// ===== tb_top.sv
// Testbench: bus, frame, break and shift tests of the serial control block
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, v;
    logic [10:0] cap;
    logic [7:0] m0 = 8'h00;
    logic wq, line, st_rx, drv, oe, txd, brk, prog;
    int fails = 0, total_checks = 0, brks = 0;
    // Receive pin: the block wins while it drives, else the station
    assign line = oe ? drv : st_rx;
    uart_serial_ctrl dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq),
        .I_RXD(line), .O_RXD(drv), .O_RXD_OE(oe), .O_TXD(txd), .O_BREAK_RESET(brk), .O_PROG_FORCE(prog));
    uart_station st (.i_txd(txd), .o_rxd(st_rx));
    // Clock and break pulse count
    initial forever #50 clk = ~clk;
    always @(posedge clk) if (brk === 1'b1 && prog === 1'b1) brks++;
    // Far side of the shift link takes data, LSB first, on each rising shift clock
    always @(posedge txd) if (oe === 1'b1) m0 <= {line, m0[7:1]};
    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task conclude;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    // Avalon cycle held until waitrequest is sampled low; a hang ends the run
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        for (n = 0; wq !== 1'b0 && n < 20; n++)
            @(posedge clk);
        v = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        chk(n < 20, 32'h1);
        if (n >= 20)
            conclude();
    endtask : bus
    task rm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(v & m, e);
    endtask : rm
    task t_reset;
        rm(uart_pkg::CTRL_OFS, 32'hFFFFFFFF, 32'h00);
        rm(uart_pkg::BAUD_OFS, 32'hFFFFFFFF, 32'h10);
        rm(8'h00, 32'hFFFFFFFF, 32'h00);
        bus(1'b1, uart_pkg::DATA_OFS, 32'h81);
        repeat (140) @(posedge clk);
        chk({24'h0, m0}, 32'h81);
        rm(uart_pkg::CTRL_OFS, 32'hFF, 32'h02);
        $display("t_reset end");
    endtask : t_reset
    task t_mode1;
        bus(1'b1, uart_pkg::CTRL_OFS, 32'h50);
        st.send(16'h034A, 10);
        rm(uart_pkg::DATA_OFS, 32'hFF, 32'hA5);
        rm(uart_pkg::CTRL_OFS, 32'hFF, 32'h55);
        rm(uart_pkg::CTRL_OFS, 32'hFF, 32'h55);
        bus(1'b1, uart_pkg::CTRL_OFS, 32'h40);
        st.send(16'h0278, 10);
        rm(uart_pkg::CTRL_OFS, 32'hFF, 32'h40);
        $display("t_mode1 end");
    endtask : t_mode1
    task t_mode3;
        bus(1'b1, uart_pkg::CTRL_OFS, 32'hF0);
        st.send(16'h0424, 11);
        rm(uart_pkg::CTRL_OFS, 32'h01, 32'h00);
        st.send(16'h0668, 11);
        rm(uart_pkg::CTRL_OFS, 32'hFF, 32'hF5);
        bus(1'b1, uart_pkg::CTRL_OFS, 32'hC8);
        fork
            st.grab(cap);
            bus(1'b1, uart_pkg::DATA_OFS, 32'h3C);
        join
        chk({21'h0, cap}, 32'h678);
        rm(uart_pkg::CTRL_OFS, 32'hFF, 32'hCA);
        $display("t_mode3 end");
    endtask : t_mode3
    task t_break;
        bus(1'b1, uart_pkg::CTRL_OFS, 32'h50);
        bus(1'b1, uart_pkg::AUXC_OFS, 32'h03);
        st.send(16'h0000, 16);
        rm(uart_pkg::STAT_OFS, 32'h03, 32'h03);
        chk(brks, 32'h1);
        st.send(16'h02B4, 10);
        rm(uart_pkg::DATA_OFS, 32'hFF, 32'h5A);
        rm(uart_pkg::CTRL_OFS, 32'h80, 32'h80);
        bus(1'b1, uart_pkg::STAT_OFS, 32'h03);
        bus(1'b1, uart_pkg::CTRL_OFS, 32'h50);
        rm(uart_pkg::CTRL_OFS, 32'h80, 32'h00);
        $display("t_break end");
    endtask : t_break
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_mode1();
        t_mode3();
        t_break();
        conclude();
    end
endmodule : tb_top
